// ==== rtl/ccvm_core.sv ====
module ccvm_core #(
   parameter longint unsigned CAL_START_CYCLES = ccvm_pkg::CAL_START_CYC,
   parameter longint unsigned CAL_RUN_CYCLES   = ccvm_pkg::CAL_RUN_CYC,
   parameter longint unsigned CONV_CYCLES      = ccvm_pkg::CONV_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 reset_n,
   input  wire ccvm_pkg::ccvm_uv_t   sense_diff_voltage,
   input  wire logic                 charge_freq_converter,
   input  wire logic [15:0]          pack_voltage_input,
   input  wire logic [3:0]           programmed_capacity,
   input  wire logic                 display_button_input,
   input  wire logic [15:0]          remaining_capacity,
   input  wire logic [15:0]          learned_capacity,
   input  wire logic                 flags_clear,
   output logic signed [31:0]        charge_count,
   output logic [15:0]               pack_voltage_reg,
   output logic                      conv_done,
   output logic                      divider_switch_oe,
   output logic [4:0]                leds,
   output ccvm_pkg::ccvm_flags_t     secondary_flags
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   ccvm_pkg::ccvm_state_t s_q;
   ccvm_pkg::ccvm_state_t s_d;

   logic [19:0] abs_uv;
   logic [19:0] filt_uv;
   logic [19:0] ovl_uv;
   logic        above_filt;
   logic        is_charge;
   logic        is_discharge;
   logic        activity;
   logic        count_ev;
   logic        conv_start;
   logic        settle_end;
   logic        ovl_now;
   logic [4:0]  bar;
   logic [18:0] rem_x5;

   // ----------------------------------------------------------------
   // Sense classification and filtering
   // ----------------------------------------------------------------
   always_comb begin
      // Most negative code wraps to itself; outside the 250 mV range anyway
      abs_uv = sense_diff_voltage[19] ? 20'(-sense_diff_voltage)
                                      : 20'(sense_diff_voltage);
   end

   // RL3 RL7 threshold select
   assign filt_uv = s_q.flags.filter_fine ? ccvm_pkg::FILT_FINE_UV
                                          : ccvm_pkg::FILT_COARSE_UV;

   // RL3 drop small counts
   assign above_filt = abs_uv >= filt_uv;

   // RL1 charge direction
   assign is_charge    = ~sense_diff_voltage[19] && (sense_diff_voltage != '0) && above_filt;
   assign is_discharge = sense_diff_voltage[19] && above_filt;

   assign activity = is_charge | is_discharge;

   // RL2 one count per clock cycle with the pulse input high
   assign count_ev = charge_freq_converter && activity;

   // ----------------------------------------------------------------
   // Overload threshold
   // ----------------------------------------------------------------
   // RL14 scaled by capacity level
   assign ovl_uv = ccvm_pkg::OVL_BASE_UV
                 + 20'(ccvm_pkg::OVL_STEP_UV * 20'(s_q.cap_level));

   assign ovl_now = s_q.cfg_loaded && (abs_uv > ovl_uv);

   // ----------------------------------------------------------------
   // Conversion timing
   // ----------------------------------------------------------------
   // RL8 two second period
   assign conv_start = ~s_q.measuring
                    && (s_q.conv_tmr == 32'(CONV_CYCLES - 64'd1));
   assign settle_end = s_q.measuring
                    && (s_q.settle == 5'(ccvm_pkg::SETTLE_CYC - 1));

   // ----------------------------------------------------------------
   // Relative display bar
   // ----------------------------------------------------------------
   assign rem_x5 = 19'(remaining_capacity) * 19'h00005;

   genvar k;
   generate
      for (k = 0; k < 5; k++) begin : g_bar
         // RL16 learned capacity is full scale
         assign bar[k] = (learned_capacity != '0)
                      && (rem_x5 > 19'(learned_capacity) * 19'(k));
      end
   endgenerate

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d           = s_q;
      s_d.conv_done = 1'b0;

      // Capacity setting is caught once, one edge after reset release
      if (!s_q.cfg_loaded) begin
         s_d.cfg_loaded = 1'b1;
         // RL14 latch capacity level
         s_d.cap_level  = programmed_capacity;
      end

      // RL2 signed accumulation
      if (count_ev) begin
         if (is_charge) begin
            s_d.charge_count = s_q.charge_count + 32'sd1;
         end else begin
            s_d.charge_count = s_q.charge_count - 32'sd1;
         end
      end

      s_d.flags.charging = is_charge;

      // Calibration sequence
      case (s_q.cal)
         ccvm_pkg::CCVM_CAL_IDLE: begin
            // RL4 wait for first valid charge
            if (count_ev && is_charge) begin
               s_d.cal     = ccvm_pkg::CCVM_CAL_WAIT;
               s_d.cal_tmr = '0;
            end
         end
         ccvm_pkg::CCVM_CAL_WAIT: begin
            // RL5 start delay bound
            if (s_q.cal_tmr >= 40'(CAL_START_CYCLES - 64'd1)) begin
               s_d.cal     = ccvm_pkg::CCVM_CAL_RUN;
               s_d.cal_tmr = '0;
            end else begin
               s_d.cal_tmr = s_q.cal_tmr + 40'd1;
            end
         end
         ccvm_pkg::CCVM_CAL_RUN: begin
            // RL6 pause on activity
            if (!activity) begin
               // RL5 completion time
               if (s_q.cal_tmr >= 40'(CAL_RUN_CYCLES - 64'd1)) begin
                  s_d.cal               = ccvm_pkg::CCVM_CAL_DONE;
                  // RL7 fine threshold
                  s_d.flags.filter_fine = 1'b1;
                  s_d.flags.cal_done    = 1'b1;
               end else begin
                  s_d.cal_tmr = s_q.cal_tmr + 40'd1;
               end
            end
         end
         ccvm_pkg::CCVM_CAL_DONE: begin
            s_d.cal_tmr = '0;
         end
         default: begin
            s_d.cal     = ccvm_pkg::CCVM_CAL_IDLE;
            s_d.cal_tmr = '0;
         end
      endcase

      // Pack voltage conversion
      if (conv_start) begin
         s_d.conv_tmr  = '0;
         // RL9 release divider switch
         s_d.measuring = 1'b1;
         s_d.settle    = '0;
      end else if (!s_q.measuring) begin
         s_d.conv_tmr = s_q.conv_tmr + 32'd1;
      end

      if (s_q.measuring) begin
         // Conversion time counts toward the period so it stays at 2 s
         s_d.conv_tmr = s_q.conv_tmr + 32'd1;
         s_d.settle   = s_q.settle + 5'd1;
      end

      if (settle_end) begin
         // RL9 drive low again
         s_d.measuring    = 1'b0;
         // RL8 store result
         s_d.pack_voltage = pack_voltage_input;
         s_d.conv_done    = 1'b1;
         // RL12 empty check held off
         if (!ovl_now) begin
            // RL10 RL11 empty level
            s_d.flags.empty = pack_voltage_input <= ccvm_pkg::EMPTY_MV;
         end
         // RL10 RL11 overvoltage on charge
         s_d.flags.max_fault = is_charge
                            && (pack_voltage_input > ccvm_pkg::MAX_CHG_MV);
      end

      // RL12 live overload level
      s_d.flags.overload_now = ovl_now;

      // RL13 sticky flag, set wins
      if (ovl_now) begin
         s_d.flags.overload_flag = 1'b1;
      end else if (flags_clear) begin
         s_d.flags.overload_flag = 1'b0;
      end

      // RL15 button or rate
      s_d.flags.display_on = display_button_input | activity;
      s_d.leds             = (display_button_input | activity) ? bar : 5'h00;
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_q.cal          <= ccvm_pkg::CCVM_CAL_IDLE;
         s_q.cal_tmr      <= 40'h00_0000_0000;
         s_q.conv_tmr     <= 32'h0000_0000;
         s_q.settle       <= 5'h00;
         s_q.measuring    <= 1'b0;
         s_q.conv_done    <= 1'b0;
         s_q.cfg_loaded   <= 1'b0;
         s_q.cap_level    <= 4'h0;
         s_q.charge_count <= 32'sh0000_0000;
         s_q.pack_voltage <= 16'h0000;
         s_q.leds         <= 5'h00;
         s_q.flags        <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign charge_count      = s_q.charge_count;
   assign pack_voltage_reg  = s_q.pack_voltage;
   assign conv_done         = s_q.conv_done;
   // RL9 pin low except while measuring
   assign divider_switch_oe = ~s_q.measuring;
   assign leds              = s_q.leds;
   // RL17 status visible
   assign secondary_flags   = s_q.flags;

endmodule : ccvm_core

// ==== inc/ccvm_pkg.sv ====
// Operation
// RL1 - Positive second-minus-first sense difference is charge, negative is discharge.
// RL2 - Each accumulated converter count stands for 3.125 microvolt-hours.
// RL3 - Counts below filter threshold are dropped; threshold is 300 uV before calibration.
// RL4 - Offset calibration starts only after first valid charge since initialization.
// RL5 - Calibration begins within 20 minutes and completes within 60 minutes.
// RL6 - Calibration pauses during charge or discharge activity, resumes afterwards.
// RL7 - Successful calibration lowers filter threshold to 100 uV.
// RL8 - Pack voltage converted every 2 seconds into the pack voltage register.
// RL9 - Divider switch released during measurement, driven low otherwise.
// RL10 - Empty when voltage falls to empty level; fault above maximum during charge.
// RL11 - Empty level 0.45 V, maximum charge level 1.00 V at pack input.
// RL12 - Empty detection suppressed while sense voltage exceeds overload threshold.
// RL13 - Overload detection sets overload flag in secondary flags.
// RL14 - Overload threshold derives from capacity setting latched at initialization.
// RL15 - Display activates on button or detected charge or discharge rate.
// RL16 - Display shows relative capacity against learned discharge capacity.
// RL17 - Filter state, calibration state and overload flag are visible as status.
package ccvm_pkg;

   localparam longint unsigned CLK_HZ         = 125_000_000;
   localparam longint unsigned CAL_START_MIN  = 20;
   localparam longint unsigned CAL_RUN_MIN    = 60;
   localparam longint unsigned CONV_PERIOD_S  = 2;
   localparam longint unsigned CAL_START_CYC  = CAL_START_MIN * 64'd60 * CLK_HZ;
   localparam longint unsigned CAL_RUN_CYC    = CAL_RUN_MIN * 64'd60 * CLK_HZ;
   localparam longint unsigned CONV_CYC       = CONV_PERIOD_S * CLK_HZ;
   localparam int unsigned     SETTLE_CYC     = 16;

   // Scale of one converter count in nano-volt-hours (3.125 uVh)
   localparam int unsigned     COUNT_NVH      = 3125;

   localparam logic [19:0]     FILT_COARSE_UV = 20'h0012C;
   localparam logic [19:0]     FILT_FINE_UV   = 20'h00064;
   localparam logic [15:0]     EMPTY_MV       = 16'h01C2;
   localparam logic [15:0]     MAX_CHG_MV     = 16'h03E8;
   localparam logic [19:0]     OVL_BASE_UV    = 20'h0C350;
   localparam logic [19:0]     OVL_STEP_UV    = 20'h02710;

   typedef logic signed [19:0] ccvm_uv_t;

   typedef enum logic [3:0] {
      CCVM_CAL_IDLE = 4'h1,
      CCVM_CAL_WAIT = 4'h2,
      CCVM_CAL_RUN  = 4'h4,
      CCVM_CAL_DONE = 4'h8
   } ccvm_cal_t;

   typedef struct packed {
      logic overload_flag;
      logic overload_now;
      logic empty;
      logic max_fault;
      logic cal_done;
      logic filter_fine;
      logic charging;
      logic display_on;
   } ccvm_flags_t;

   typedef struct packed {
      ccvm_cal_t          cal;
      logic [39:0]        cal_tmr;
      logic [31:0]        conv_tmr;
      logic [4:0]         settle;
      logic               measuring;
      logic               conv_done;
      logic               cfg_loaded;
      logic [3:0]         cap_level;
      logic signed [31:0] charge_count;
      logic [15:0]        pack_voltage;
      logic [4:0]         leds;
      ccvm_flags_t        flags;
   } ccvm_state_t;

endpackage : ccvm_pkg

// ==== test/ccvm_cell_model.sv ====
module ccvm_cell_model (
   divider_switch_oe,
   sense_set,
   pulse_set,
   pack_mv,
   sense_diff_voltage,
   charge_freq_converter,
   pack_voltage_input
);
   timeunit 1ns;
   timeprecision 1ps;
   input  wire logic               divider_switch_oe;
   input  wire ccvm_pkg::ccvm_uv_t sense_set;
   input  wire logic               pulse_set;
   input  wire logic [15:0]        pack_mv;
   output ccvm_pkg::ccvm_uv_t      sense_diff_voltage;
   output logic                    charge_freq_converter;
   output logic [15:0]             pack_voltage_input;
   assign sense_diff_voltage    = sense_set;
   assign charge_freq_converter = pulse_set;
   // Divider off the cells: the line floats, so show the inverse rather than a stale value
   assign pack_voltage_input    = divider_switch_oe ? ~pack_mv : pack_mv;
endmodule : ccvm_cell_model

// ==== test/ccvm_core_chk.sv ====
module ccvm_core_chk #(
   parameter longint unsigned CONV_CYCLES = 64
) (
   input wire logic                  clk,
   input wire logic                  reset_n,
   input wire ccvm_pkg::ccvm_uv_t    sense_diff_voltage,
   input wire logic                  charge_freq_converter,
   input wire logic [15:0]           pack_voltage_input,
   input wire logic [3:0]            programmed_capacity,
   input wire logic                  display_button_input,
   input wire logic                  flags_clear,
   input wire logic signed [31:0]    charge_count,
   input wire logic [15:0]           pack_voltage_reg,
   input wire logic                  conv_done,
   input wire logic                  divider_switch_oe,
   input wire logic [4:0]            leds,
   input wire ccvm_pkg::ccvm_flags_t secondary_flags
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [19:0] mag;
   logic [19:0] ovl_thr;
   logic [31:0] gap_q;
   logic        seen_q;
   assign mag     = sense_diff_voltage[19] ? 20'(-sense_diff_voltage) : 20'(sense_diff_voltage);
   assign ovl_thr = ccvm_pkg::OVL_BASE_UV + ccvm_pkg::OVL_STEP_UV * 20'(programmed_capacity);
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         gap_q  <= 32'h0;
         seen_q <= 1'b0;
      end else begin
         gap_q  <= conv_done ? 32'h1 : gap_q + 32'h1;
         seen_q <= seen_q | conv_done;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   AST_CHG_CNT: assert property (charge_freq_converter && sense_diff_voltage >= 300 |=>
      charge_count == $past(charge_count) + 1) else $error("charge pulse not counted up");
   AST_DIS_CNT: assert property (charge_freq_converter && sense_diff_voltage <= -300 |=>
      charge_count == $past(charge_count) - 1) else $error("discharge pulse not counted down");
   AST_IDLE_CNT: assert property (!charge_freq_converter || mag < 100 |=> $stable(charge_count))
      else $error("count moved without valid pulse");
   AST_COARSE: assert property (charge_freq_converter && mag < 300 && !secondary_flags.filter_fine
      |=> $stable(charge_count)) else $error("coarse filter let a small pulse through");
   AST_FINE: assert property (charge_freq_converter && mag >= 100 && secondary_flags.filter_fine
      |=> charge_count != $past(charge_count)) else $error("fine filter dropped a pulse");
   AST_DIV: assert property ($fell(divider_switch_oe) |-> (!divider_switch_oe)[*8] ##1
      (!divider_switch_oe)[*8] ##1 (divider_switch_oe && conv_done)) else $error("divider window wrong");
   AST_CONV: assert property (conv_done |-> pack_voltage_reg == $past(pack_voltage_input))
      else $error("pack voltage not taken at end of measurement");
   AST_PERIOD: assert property (conv_done && seen_q |-> gap_q == CONV_CYCLES)
      else $error("conversion period wrong");
   AST_OVL: assert property ($past(reset_n) && mag > ovl_thr |=> secondary_flags.overload_now &&
      secondary_flags.overload_flag) else $error("overload not flagged");
   AST_STICKY: assert property (secondary_flags.overload_flag && !flags_clear |=>
      secondary_flags.overload_flag) else $error("overload flag lost");
   AST_DISPLAY_BUTTON_INPUT: assert property (display_button_input |=> secondary_flags.display_on)
      else $error("button did not light display");
   AST_LED_OFF: assert property (!secondary_flags.display_on |-> leds == 5'h00)
      else $error("leds lit with display off");
   cover property (conv_done);
   cover property ($rose(secondary_flags.filter_fine));
   cover property ($rose(secondary_flags.overload_flag));
   cover property ($rose(secondary_flags.max_fault));
endmodule : ccvm_core_chk
bind ccvm_core ccvm_core_chk #(.CONV_CYCLES(CONV_CYCLES)) chk (.clk, .reset_n, .sense_diff_voltage,
   .charge_freq_converter, .pack_voltage_input, .programmed_capacity, .display_button_input, .flags_clear,
   .charge_count, .pack_voltage_reg, .conv_done, .divider_switch_oe, .leds, .secondary_flags);

// ==== test/ccvm_core_tb.sv ====
module ccvm_core_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, reset_n = 0, pulse = 0, button = 0, flags_clear = 0, cfc, conv_done, oe;
   ccvm_pkg::ccvm_uv_t sense = '0, sense_w;
   logic [15:0] pack = 16'h012C, pack_w, rem = '0, lrn = '0, pack_reg, tbl [5];
   logic [3:0] cap = 4'h0;
   logic signed [31:0] charge_count, exp_cnt = '0;
   logic [4:0] leds;
   ccvm_pkg::ccvm_flags_t fl;
   int miscompares = 0, n_checks = 0, thr, i;
   always #4 clk = ~clk;
   ccvm_cell_model cells (.divider_switch_oe(oe), .sense_set(sense), .pulse_set(pulse), .pack_mv(pack),
      .sense_diff_voltage(sense_w), .charge_freq_converter(cfc), .pack_voltage_input(pack_w));
   ccvm_core #(.CAL_START_CYCLES(20), .CAL_RUN_CYCLES(30), .CONV_CYCLES(64)) uut (.clk, .reset_n,
      .sense_diff_voltage(sense_w), .charge_freq_converter(cfc), .pack_voltage_input(pack_w),
      .programmed_capacity(cap), .display_button_input(button), .remaining_capacity(rem),
      .learned_capacity(lrn), .flags_clear, .charge_count, .pack_voltage_reg(pack_reg), .conv_done,
      .divider_switch_oe(oe), .leds, .secondary_flags(fl));
   // --------------------------------
   // Expectations and drivers
   // --------------------------------
   function automatic int delta(input int s, input logic p, input int t);
      if (!p || (s < t && s > -t)) return 0;
      return s > 0 ? 1 : -1;
   endfunction : delta
   function automatic logic [4:0] bar(input longint r, input longint l);
      for (int k = 0; k < 5; k++) bar[k] = l != 0 && r * 5 > k * l;
   endfunction : bar
   task automatic check(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic give_verdict;
      $display("checks %0d miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : give_verdict
   task automatic step(input int s, input logic p, input int t);
      sense = ccvm_pkg::ccvm_uv_t'(s);
      pulse = p;
      exp_cnt += delta(s, p, t);
      @(negedge clk);
   endtask : step
   // Two completions, so the result belongs wholly to the pack value set before
   task automatic conv2;
      for (int n = 0; n < 2; n++) begin
         int w = 0;
         do @(negedge clk); while (conv_done !== 1'b1 && ++w < 200);
         if (conv_done !== 1'b1) begin
            check(1'b0, "conversion timeout");
            give_verdict();
         end
      end
      @(negedge clk);
   endtask : conv2
   initial begin
      void'($urandom(79740));
      cap = 4'($urandom_range(15));
      thr = int'(ccvm_pkg::OVL_BASE_UV) + int'(ccvm_pkg::OVL_STEP_UV) * cap;
      repeat (3) @(posedge clk);
      @(negedge clk);
      check(oe === 1'b1 && charge_count === 0 && fl === '0 && leds === 5'h00, "reset state");
      reset_n = 1;
      repeat (80) step(-int'($urandom_range(600)), 1'($urandom_range(1)), 300);
      step(-300, 1, 300);
      step(-299, 1, 300);
      check(charge_count === exp_cnt, "discharge count");
      check(fl.charging === 1'b0, "charging flag on discharge");
      check(fl.cal_done === 1'b0, "calibration before any charge");
      step(299, 1, 300);
      step(300, 1, 300);
      repeat (30) step(0, 0, 300);
      repeat (60) step(400, 0, 300);
      check(fl.cal_done === 1'b0 && fl.filter_fine === 1'b0, "calibration not paused");
      check(fl.charging === 1'b1, "charging flag on charge");
      for (i = 0; i < 80 && fl.filter_fine !== 1'b1; i++) step(0, 0, 300);
      check(fl.filter_fine === 1'b1 && fl.cal_done === 1'b1, "fine filter after calibration");
      repeat (120) step(int'($urandom_range(1200)) - 600, 1'($urandom_range(1)), 100);
      step(99, 1, 100);
      step(-100, 1, 100);
      step(0, 0, 100);
      check(charge_count === exp_cnt, "count with fine filter");
      tbl = '{16'h01C3, 16'h0064, 16'($urandom_range(2000)), 16'h01C2, 16'h03E9};
      foreach (tbl[n]) begin
         pack = tbl[n];
         conv2();
         check(pack_reg === tbl[n] && fl.empty === (tbl[n] <= 16'h01C2), "conversion");
         check(fl.max_fault === 1'b0, "max fault without charge");
      end
      sense = 20'sh00190;
      pack = 16'h03E9;
      conv2();
      check(fl.max_fault === 1'b1 && pack_reg === 16'h03E9, "max fault on charge");
      pack = 16'h03E8;
      conv2();
      check(fl.max_fault === 1'b0, "max fault at level");
      sense = ccvm_pkg::ccvm_uv_t'(thr);
      repeat (3) @(negedge clk);
      check(fl.overload_now === 1'b0, "overload at threshold");
      sense = ccvm_pkg::ccvm_uv_t'(thr + 1);
      pack = 16'h0064;
      conv2();
      check(fl.empty === 1'b0 && fl.overload_flag === 1'b1, "empty under overload");
      sense = '0;
      conv2();
      check(fl.empty === 1'b1 && fl.overload_flag === 1'b1, "empty restored");
      sense = ccvm_pkg::ccvm_uv_t'(thr + 1);
      flags_clear = 1;
      @(negedge clk);
      flags_clear = 0;
      sense = '0;
      @(negedge clk);
      check(fl.overload_flag === 1'b1, "overload set beats clear");
      flags_clear = 1;
      @(negedge clk);
      flags_clear = 0;
      @(negedge clk);
      check(fl.overload_flag === 1'b0, "overload flag clear");
      rem = 16'($urandom);
      lrn = 16'($urandom);
      check(fl.display_on === 1'b0 && leds === 5'h00, "display idle");
      button = 1;
      repeat (2) @(negedge clk);
      check(fl.display_on === 1'b1 && leds === bar(rem, lrn), "led bar");
      lrn = '0;
      repeat (2) @(negedge clk);
      check(leds === 5'h00, "led bar without learned capacity");
      button = 0;
      sense = 20'sh00190;
      repeat (2) @(negedge clk);
      check(fl.display_on === 1'b1, "display on activity");
      give_verdict();
   end
endmodule : ccvm_core_tb
